/* src/interleaved_multiphase_pwm.sv */
// Interleaved six-phase PWM timing with strap detection, phase dropping and tri-level outputs
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`include "pwm_defs.svh"
`default_nettype none

module interleaved_multiphase_pwm
  import pwm_pkg::*;
#(
  parameter int NPH = 6
)(
  input  wire logic              clk,
  input  wire logic              reset,
  // Avalon-MM slave
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // Phase pins, open for strap sensing
  input  wire logic [NPH-1:0]    phaseIn,
  output logic [NPH-1:0]         phaseOut,
  output logic [NPH-1:0]         phaseOe_n,
  output logic                   driveEnable
);

  // ============================================================
  // Registers and state
  logic [31:0]     ctrl_q;
  logic [15:0]     period_q;
  logic [15:0]     duty_q;
  logic [15:0]     load_q;
  logic [15:0]     thresh_q;
  logic            ack_q;
  logic [31:0]     rdata_q;
  state_t          state_q;
  logic [11:0]     detCnt_q;
  logic [NPH-1:0]  sync1_q;
  logic [NPH-1:0]  sync2_q;
  logic [2:0]      cfgN_q;
  logic [2:0]      effN_q;
  logic [15:0]     slotCnt_q;
  logic [2:0]      slotIdx_q;
  logic            drvEn_q;
  logic            light_q;
  logic            skip_q;
  logic [15:0]     onCnt_q [NPH];
  logic [NPH-1:0]  outLvl_q;
  logic [NPH-1:0]  outMid_q;

  // ============================================================
  // Mode decode
  wire autoDrop = ctrl_q[`CTRL_AUTODROP];
  wire triLevel = ctrl_q[`CTRL_TRILEVEL];
  wire polarity = ctrl_q[`CTRL_POLARITY];
  wire runReq   = ctrl_q[`CTRL_START];
  wire audio    = ~autoDrop & triLevel;

  // Slot length of period over phase count
  function automatic logic [15:0] slotOf(input logic [15:0] p, input logic [2:0] n);
    case (n)
      3'd2:    slotOf = p >> 1;
      3'd3:    slotOf = p / 16'd3;
      3'd4:    slotOf = p >> 2;
      default: slotOf = p / 16'd6;
    endcase
  endfunction

  wire [15:0] slotLen  = slotOf(period_q, effN_q);
  wire        slotEnd  = slotCnt_q >= slotLen - 16'd1;
  wire        periodEnd = slotEnd && (slotIdx_q == effN_q - 3'd1);
  wire [15:0] audioMin = period_q / 16'(`AUDIO_DIV);
  wire [15:0] minOn    = audio ? audioMin : 16'(`MIN_ON_CYCLES);
  // Forced minimum only where pulses must not be skipped
  wire [15:0] onReq    = (audio && duty_q < minOn) ? minOn : duty_q;
  wire [15:0] perUsed  = 16'(slotLen * 16'(effN_q));
  // Pulse never outlasts the period, so the next start still sees a low level
  wire [15:0] onTime   = (onReq >= perUsed) ? perUsed - 16'd1 : onReq;
  wire        isRun    = state_q == ST_RUN;
  wire        canRun   = runReq && period_q >= `MIN_PERIOD;

  // Strap decode at end of detection window
  wire        detDone  = detCnt_q == 12'(`DETECT_CYCLES - 1);
  wire        badStrap = sync2_q[0] | sync2_q[1];
  wire [2:0]  strapN   = sync2_q[2] ? 3'd2 :
                         sync2_q[3] ? 3'd3 :
                         (sync2_q[4] | sync2_q[5]) ? 3'd4 :
                         3'd6;

  // Load compare for dropping and skipping
  wire        lightNow = autoDrop && load_q < thresh_q;
  wire        deepNow  = autoDrop && load_q < (thresh_q >> 1);
  // Light load keeps two phases; otherwise every configured phase runs
  wire [2:0]  dropN    = lightNow ? 3'd2 : cfgN_q;

  // ============================================================
  // Bus decode
  wire access   = read | write;
  wire selCtrl  = address == `OFS_CTRL;
  wire selPer   = address == `OFS_PERIOD;
  wire selDuty  = address == `OFS_DUTY;
  wire selLoad  = address == `OFS_LOAD;
  wire selThr   = address == `OFS_THRESH;
  wire selStat  = address == `OFS_STATUS;
  wire wrTake   = write & ack_q;
  wire [31:0] statusWord = {20'h00000, drvEn_q, (state_q == ST_LATCHED), effN_q, cfgN_q, light_q, skip_q,
                            isRun, 1'b0};
  wire [31:0] rdMux = selCtrl ? ctrl_q :
                      selPer  ? {16'h0000, period_q} :
                      selDuty ? {16'h0000, duty_q} :
                      selLoad ? {16'h0000, load_q} :
                      selThr  ? {16'h0000, thresh_q} :
                      selStat ? statusWord : 32'h0000_0000;

  assign waitrequest = access & ~ack_q;
  assign readdata    = rdata_q;

  // Bus answer one cycle after request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= access & ~ack_q;
      rdata_q <= (read & ~ack_q) ? rdMux : rdata_q;
    end
  end

  // Register writes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q   <= `CTRL_RESET;
      period_q <= `PERIOD_RESET;
      duty_q   <= `DUTY_RESET;
      load_q   <= `LOAD_RESET;
      thresh_q <= `THRESH_RESET;
    end
    else if (wrTake)
    begin
      if (selCtrl)
        ctrl_q <= {28'h0000000, writedata[3:0]};
      else if (selPer)
        period_q <= writedata[15:0];
      else if (selDuty)
        duty_q <= writedata[15:0];
      else if (selLoad)
        load_q <= writedata[15:0];
      else if (selThr)
        thresh_q <= writedata[15:0];
    end
  end

  // ============================================================
  // Strap pin synchroniser
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= phaseIn;
      sync2_q <= sync1_q;
    end
  end

  // Detection, idle, run and latch-off sequence
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q  <= ST_DETECT;
      detCnt_q <= 12'h000;
      cfgN_q   <= 3'd6;
    end
    else
    begin
      case (state_q)
        ST_DETECT:
        begin
          detCnt_q <= detCnt_q + 12'h001;
          if (detDone)
          begin
            cfgN_q  <= strapN;
            state_q <= badStrap ? ST_LATCHED : ST_IDLE;
          end
        end
        ST_IDLE:
          if (canRun)
            state_q <= ST_RUN;
        ST_RUN:
          if (!runReq && periodEnd)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_LATCHED;
      endcase
    end
  end

  // Slot sequencer; phase count changes only at period end or while not running
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      slotCnt_q <= 16'h0000;
      slotIdx_q <= 3'd0;
      effN_q    <= 3'd6;
      light_q   <= 1'b0;
      skip_q    <= 1'b0;
    end
    else if (!isRun || periodEnd)
    begin
      slotCnt_q <= 16'h0000;
      slotIdx_q <= 3'd0;
      effN_q    <= dropN;
      light_q   <= lightNow;
      skip_q    <= deepNow & triLevel;
    end
    else if (slotEnd)
    begin
      slotCnt_q <= 16'h0000;
      slotIdx_q <= slotIdx_q + 3'd1;
    end
    else
      slotCnt_q <= slotCnt_q + 16'h0001;
  end

  // ============================================================
  // Per-phase pulse generators
  genvar g;
  generate
    for (g = 0; g < NPH; g++)
    begin : gPhase
      wire used  = 3'(g) < effN_q;
      wire start = isRun && used && slotCnt_q == 16'h0000 && slotIdx_q == 3'(g);
      wire fire  = start && onTime != 16'h0000 && !skip_q;
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          onCnt_q[g]  <= 16'h0000;
          outLvl_q[g] <= 1'b0;
          outMid_q[g] <= 1'b1;
        end
        else if (!isRun || !used)
        begin
          onCnt_q[g]  <= 16'h0000;
          outLvl_q[g] <= 1'b0;
          outMid_q[g] <= 1'b1;
        end
        else if (fire)
        begin
          onCnt_q[g]  <= onTime - 16'h0001;
          outLvl_q[g] <= 1'b1;
          outMid_q[g] <= 1'b0;
        end
        else if (onCnt_q[g] != 16'h0000)
          onCnt_q[g] <= onCnt_q[g] - 16'h0001;
        else
        begin
          outLvl_q[g] <= 1'b0;
          outMid_q[g] <= triLevel & light_q;
        end
      end
    end
  endgenerate

  // Driver enable rises one cycle after the first pulse starts and holds while running
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      drvEn_q <= 1'b0;
    else if (!isRun)
      drvEn_q <= 1'b0;
    else if (|outLvl_q)
      drvEn_q <= 1'b1;
  end

  // Mask of channels inside a phase count
  function automatic logic [NPH-1:0] gUsedMask(input logic [2:0] n);
    for (int i = 0; i < NPH; i++)
      gUsedMask[i] = 3'(i) < n;
  endfunction

  // ============================================================
  // Pin drive: released pins give the middle level or strap sense
  // Strapped pins lie outside the configured count, or latch the block off, and are never driven
  wire           driveAll = isRun;
  wire           idleMid  = (state_q == ST_IDLE) & triLevel;
  wire           relAll   = (state_q == ST_DETECT) | (state_q == ST_LATCHED) | idleMid;
  wire [NPH-1:0] usedRun  = gUsedMask(effN_q);
  wire [NPH-1:0] usedCfg  = gUsedMask(cfgN_q);
  assign phaseOut    = (outLvl_q ^ {NPH{polarity}});
  assign phaseOe_n   = driveAll ? (outMid_q & {NPH{triLevel}}) | ~usedRun
                                : (relAll ? {NPH{1'b1}} : ~usedCfg);
  assign driveEnable = drvEn_q;

endmodule // interleaved_multiphase_pwm
`default_nettype wire

/* src/pwm_defs.svh */
// Offsets, field positions, reset values and timing counts of the multiphase PWM block
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// ============================================================
// Register byte offsets
`define OFS_CTRL        6'h00
`define OFS_PERIOD      6'h04
`define OFS_DUTY        6'h08
`define OFS_LOAD        6'h0C
`define OFS_THRESH      6'h10
`define OFS_STATUS      6'h14

// ============================================================
// Control fields
`define CTRL_AUTODROP   0
`define CTRL_TRILEVEL   1
`define CTRL_POLARITY   2
`define CTRL_START      3
`define CTRL_RESET      32'h0000_0000

// ============================================================
// Reset values of data registers
`define PERIOD_RESET    16'h03E8
`define DUTY_RESET      16'h0000
`define LOAD_RESET      16'h0000
`define THRESH_RESET    16'h0000

// ============================================================
// Timing
`define CLK_MHZ         100
`define DETECT_US       30
`define DETECT_CYCLES   (`DETECT_US * `CLK_MHZ)
`define MIN_ON_NS       130
`define MIN_ON_CYCLES   ((`MIN_ON_NS * `CLK_MHZ + 999) / 1000)
`define AUDIO_DIV       12
`define MIN_PERIOD      16'h000C

`endif

/* src/pwm_pkg.sv */
// Types shared by the multiphase PWM block
`default_nettype none
package pwm_pkg;
  typedef enum logic [1:0] {
    ST_DETECT,
    ST_IDLE,
    ST_RUN,
    ST_LATCHED
  } state_t;
endpackage
`default_nettype wire

/* verif/phase_driver_model.sv */
// Gate drivers and strap resistors at the phase pins
`default_nettype none
module phase_driver_model #(
  parameter int NPH = 6
)(
  input  wire logic [NPH-1:0] phaseOut,
  input  wire logic [NPH-1:0] phaseOe_n,
  input  wire logic [NPH-1:0] strap,
  input  wire logic           driveEnable,
  output logic [NPH-1:0]      pinLevel,
  output logic [NPH-1:0]      lowOn
);
  // Strap pull-up wins; a released unstrapped pin rests at the driver bias, read low
  assign pinLevel = strap | (phaseOut & ~phaseOe_n);
  // Inverting driver: low level turns the switch on, released level turns both off
  assign lowOn = {NPH{driveEnable}} & ~phaseOut & ~phaseOe_n;
endmodule // phase_driver_model
`default_nettype wire

/* verif/interleaved_multiphase_pwm_checker.sv */
// Assertion checker for the interleaved PWM block
`default_nettype none
module interleaved_multiphase_pwm_checker
  import pwm_pkg::*;
#(
  parameter int NPH = 6
)(
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           read,
  input wire logic           write,
  input wire logic [31:0]    readdata,
  input wire logic           waitrequest,
  input wire logic [NPH-1:0] phaseIn,
  input wire logic [NPH-1:0] phaseOut,
  input wire logic [NPH-1:0] phaseOe_n,
  input wire logic           driveEnable
);
  int unsigned    cnt_q;
  logic [NPH-1:0] strap_q;
  // ========================================
  // Cycles since release, straps seen in detection
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      cnt_q   <= 0;
      strap_q <= '0;
    end
    else
    begin
      if (cnt_q < 4000)
        cnt_q <= cnt_q + 1;
      if (cnt_q == 100)
        strap_q <= phaseIn;
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ========================================
  // Handshake and pin behaviour
  wait_first_a: assert property ($rose(read || write) |-> waitrequest) else $error("no wait cycle");
  wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
  reset_out_a: assert property ($past(reset) |-> phaseOut == '0
    && phaseOe_n == '1 && !driveEnable && readdata == '0) else $error("bad outputs after reset");
  detect_hold_a: assert property (cnt_q < 2995 |-> phaseOe_n == '1 && !driveEnable)
    else $error("pins driven in detection");
  latch_off_a: assert property (cnt_q > 100 && strap_q[1:0] != '0 |-> !driveEnable && $stable(phaseOut))
    else $error("runs while latched");
  strap_free_a: assert property (cnt_q > 100 |-> (strap_q & ~phaseOe_n) == '0)
    else $error("strapped pin driven");
  first_on_a: assert property ($rose(phaseOut[0] & ~phaseOe_n[0]) |-> ##[0:1] driveEnable)
    else $error("enable late");
  enable_late_a: assert property ($rose(driveEnable) |-> cnt_q >= 2995 && strap_q[1:0] == '0)
    else $error("enable early");
endmodule // interleaved_multiphase_pwm_checker
bind interleaved_multiphase_pwm interleaved_multiphase_pwm_checker #(.NPH(NPH)) chk_u (.clk(clk), .reset(reset),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .phaseIn(phaseIn),
  .phaseOut(phaseOut), .phaseOe_n(phaseOe_n), .driveEnable(driveEnable));
`default_nettype wire

/* verif/interleaved_multiphase_pwm_tb.sv */
// Self-checking bench for the interleaved PWM block
`default_nettype none
module interleaved_multiphase_pwm_tb
  import pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [5:0] st; logic [3:0] ct; logic [7:0] du; logic [2:0] cn, en, np; logic [7:0] wd;} row_t;
  localparam int PER = 120;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        mon = 1'b0;
  logic [5:0]  address = 6'h00;
  logic [5:0]  strap = 6'h00;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, rdq;
  logic        waitrequest, driveEnable;
  logic [5:0]  phaseIn, phaseOut, phaseOe_n, prevOut, drv, rel, lowOn;
  int          num_errors, checks_done, cyc, wd0, nRise[6], r0[6], r1[6];
  // Strap, control, duty, configured count, effective count, pulsing count, width
  row_t rows[8] = '{'{6'h00, 4'h8, 8'h05, 3'h6, 3'h6, 3'h6, 8'h05}, '{6'h30, 4'h8, 8'h05, 3'h4, 3'h4, 3'h4, 8'h05},
    '{6'h20, 4'h8, 8'h05, 3'h4, 3'h4, 3'h4, 8'h05}, '{6'h38, 4'h8, 8'h05, 3'h3, 3'h3, 3'h3, 8'h05},
    '{6'h3C, 4'h8, 8'h05, 3'h2, 3'h2, 3'h2, 8'h05}, '{6'h00, 4'h9, 8'h05, 3'h6, 3'h2, 3'h2, 8'h05},
    '{6'h00, 4'hA, 8'h00, 3'h6, 3'h6, 3'h6, 8'h0A}, '{6'h00, 4'hB, 8'h05, 3'h6, 3'h2, 3'h0, 8'h05}};
  interleaved_multiphase_pwm #(.NPH(6)) dut_u (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .phaseIn(phaseIn),
    .phaseOut(phaseOut), .phaseOe_n(phaseOe_n), .driveEnable(driveEnable));
  phase_driver_model #(.NPH(6)) gate_u (.phaseOut(phaseOut), .phaseOe_n(phaseOe_n), .strap(strap),
    .driveEnable(driveEnable), .pinLevel(phaseIn), .lowOn(lowOn));
  always #5 clk = ~clk;
  // ========================================
  // Pin monitor: pulse starts, widths, drive and release
  always @(negedge clk)
  begin
    cyc++;
    for (int k = 0; k < 6; k++)
    begin
      if (phaseOut[k] && !prevOut[k] && !phaseOe_n[k])
      begin
        if (nRise[k] == 0) r0[k] = cyc;
        if (nRise[k] == 1) r1[k] = cyc;
        nRise[k]++;
      end
      if (k == 0 && nRise[0] == 1 && phaseOut[0] && !phaseOe_n[0]) wd0++;
      drv[k] |= !phaseOe_n[k];
      rel[k] |= mon && phaseOe_n[k];
    end
    prevOut = phaseOut;
  end
  // ========================================
  // Bus, compare and setup tasks
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read      <= !wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    // Request stands until waitrequest is seen low at a rising edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    rdq = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 20) num_errors++;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %0h got %0h", nm, e, s);
    end
  endtask
  task automatic setup(input logic [5:0] s);
    strap <= s;
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (3010) @(posedge clk);
    nRise = '{6{0}};
    drv = 6'h00;
    rel = 6'h00;
    wd0 = 0;
    mon = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ========================================
  // Table of straps and modes, then reset values and latch-off
  initial
  begin
    foreach (rows[i])
    begin
      setup(rows[i].st);
      chk("idleEnable", driveEnable, 1'b0);
      bus(1'b1, 6'h04, 32'h0000_0078);
      bus(1'b1, 6'h08, rows[i].du);
      bus(1'b1, 6'h0C, 32'h0000_0001);
      bus(1'b1, 6'h10, 32'h0000_0064);
      bus(1'b1, 6'h00, rows[i].ct);
      repeat (PER) @(posedge clk);
      mon <= 1'b1;
      repeat (2 * PER) @(posedge clk);
      bus(1'b0, 6'h14, 32'h0000_0000);
      chk("cfgN", rdq[6:4], rows[i].cn);
      chk("effN", rdq[9:7], rows[i].en);
      chk("skip", rdq[2], rows[i].np == 0);
      chk("enable", driveEnable, rows[i].np != 0);
      for (int k = 0; k < 6; k++)
      begin
        chk("pulsed", nRise[k] != 0, k < rows[i].np);
        if (k < rows[i].np) chk("gap", r0[k] - r0[0], k * PER / rows[i].np);
        if (k >= rows[i].cn) chk("unused", drv[k], 1'b0);
        if (!rows[i].ct[1] && k < rows[i].np) chk("twoLevel", rel[k], 1'b0);
      end
      if (rows[i].np != 0) chk("period", r1[0] - r0[0], PER);
      if (rows[i].np != 0) chk("width", wd0, rows[i].wd);
      if (rows[i].np == 0) chk("middle", rel[0], 1'b1);
    end
    setup(6'h00);
    bus(1'b0, 6'h04, 32'h0000_0000);
    chk("periodReset", rdq, 32'h0000_03E8);
    bus(1'b0, 6'h00, 32'h0000_0000);
    chk("ctrlReset", rdq, 32'h0000_0000);
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3C, 32'h0000_0000);
    chk("unmapped", rdq, 32'h0000_0000);
    setup(6'h01);
    bus(1'b1, 6'h00, 32'h0000_0008);
    repeat (2 * PER) @(posedge clk);
    bus(1'b0, 6'h14, 32'h0000_0000);
    chk("latched", rdq[10], 1'b1);
    chk("latchRun", nRise[0] != 0, 1'b0);
    chk("latchEnable", driveEnable, 1'b0);
    chk("latchDrive", lowOn, 6'h00);
    summarize();
  end
  // Watchdog: the tests need some 35000 cycles
  initial
  begin
    #700000;
    num_errors++;
    summarize();
  end
endmodule // interleaved_multiphase_pwm_tb
`default_nettype wire
